//--- hw/i2c_evt_consts.svh
`ifndef I2C_EVT_CONSTS_SVH
`define I2C_EVT_CONSTS_SVH

// Event slots carried from the link domain to the module clock domain.
`define EV_DONE   0
`define EV_ADDR   1
`define EV_ARB    2
`define EV_START  3
`define EV_STOP   4
`define EV_LOWTO  5
`define EV_HOLDTO 6
`define EV_NUM    7

// Glitch filter count width, the idle level of the filtered bus lines and the reset level of the pending flag.
`define GF_W      5
`define FILT_RST  1'b1
`define FLAG_RST  1'b0

`endif

//--- hw/i2c_evt_pkg.sv
package i2c_evt_pkg;

  typedef struct packed {
    logic fall8;
    logic fall9;
    logic addr_match;
    logic general_call;
    logic arb_data_low;
    logic arb_ack_low;
    logic arb_start_busy;
    logic arb_rstart_slave;
    logic arb_unreq_stop;
    logic start_det;
    logic stop_det;
    logic low_timeout;
    logic high_low_timeout;
    logic idle_timeout;
  } link_ev_t;

  typedef struct packed {
    logic module_enable;
    logic bus_irq_enable;
    logic start_stop_irq_enable;
    logic clk_high_data_low_irq_enable;
    logic wakeup_enable;
    logic fast_ack_enable;
    logic general_call_enable;
    logic dma_request_enable;
    logic smbus_mode;
    logic low_power;
  } ctrl_t;

  typedef struct packed {
    logic bus_event;
    logic clock_low_timeout;
    logic arbitration_lost;
    logic start_seen;
    logic stop_seen;
    logic clk_high_data_low;
    logic addressed_as_slave;
    logic data_access;
  } clr_t;

  typedef struct packed {
    logic bus_event_flag;
    logic transfer_done_flag;
    logic addressed_as_slave_flag;
    logic arbitration_lost_flag;
    logic start_seen_flag;
    logic stop_seen_flag;
    logic clock_low_timeout_flag;
    logic clk_high_data_low_timeout_flag;
    logic bus_idle_timeout_flag;
  } status_t;

endpackage

//--- hw/i2c_event_irq_dma_wakeup.sv
`timescale 1ns/1ns
`include "i2c_evt_consts.svh"
module i2c_event_irq_dma_wakeup (
  input  wire logic                  CLOCK_IN,
  input  wire logic                  RESETN_IN,
  input  wire logic                  LINK_CLK_IN,
  input  wire i2c_evt_pkg::link_ev_t LINK_EV_IN,
  input  wire i2c_evt_pkg::ctrl_t    CTRL_IN,
  input  wire i2c_evt_pkg::clr_t     CLR_IN,
  input  wire logic [`GF_W-1:0]      GLITCH_CYCLES_IN,
  input  wire logic                  SCL_PIN_IN,
  input  wire logic                  SDA_PIN_IN,
  output logic                       SCL_FILT_OUT,
  output logic                       SDA_FILT_OUT,
  output logic                       IRQ_OUT,
  output logic                       DMA_REQ_OUT,
  output logic                       WAKE_OUT,
  output i2c_evt_pkg::status_t       STATUS_OUT
);
  import i2c_evt_pkg::*;

  logic [1:0]         lrst_ff;
  logic [1:0]         lcfg1_ff;
  logic [1:0]         lcfg2_ff;
  logic [`EV_NUM-1:0] l_ev;
  logic [`EV_NUM-1:0] ltog_ff;
  logic [`EV_NUM-1:0] mtog1_ff;
  logic [`EV_NUM-1:0] mtog2_ff;
  logic [`EV_NUM-1:0] mtog3_ff;
  logic [`EV_NUM-1:0] ev;
  logic               idle1_ff;
  logic               idle2_ff;
  logic               en;
  logic               cpu_src;
  logic               oth_pend_ff;
  logic               nxt_oth_pend;
  status_t            st_ff;
  status_t            nxt_st;
  logic               irq_ff;
  logic               dma_ff;
  logic               wake_ff;
  logic [1:0]         pin_raw;
  logic [1:0]         pin_filt;

  // Link domain reset follows the module reset through two flops of its own.
  always_ff @(posedge LINK_CLK_IN) begin
    lrst_ff <= {lrst_ff[0], RESETN_IN};
  end

  always_ff @(posedge LINK_CLK_IN) begin
    if (!lrst_ff[1]) begin
      lcfg1_ff <= 2'h0;
      lcfg2_ff <= 2'h0;
    end else begin
      lcfg1_ff <= {CTRL_IN.general_call_enable, CTRL_IN.fast_ack_enable};
      lcfg2_ff <= lcfg1_ff;
    end
  end

  always_comb begin
    l_ev = '0;
    l_ev[`EV_DONE]   = lcfg2_ff[0] ? LINK_EV_IN.fall8 : LINK_EV_IN.fall9;
    l_ev[`EV_ADDR]   = LINK_EV_IN.addr_match |
                       (LINK_EV_IN.general_call & lcfg2_ff[1]);
    l_ev[`EV_ARB]    = LINK_EV_IN.arb_data_low | LINK_EV_IN.arb_ack_low |
                       LINK_EV_IN.arb_start_busy | LINK_EV_IN.arb_rstart_slave |
                       LINK_EV_IN.arb_unreq_stop;
    l_ev[`EV_START]  = LINK_EV_IN.start_det;
    l_ev[`EV_STOP]   = LINK_EV_IN.stop_det;
    l_ev[`EV_LOWTO]  = LINK_EV_IN.low_timeout;
    l_ev[`EV_HOLDTO] = LINK_EV_IN.high_low_timeout;
  end

  // Events cross as toggles so a single link pulse is never missed or doubled.
  always_ff @(posedge LINK_CLK_IN) begin
    if (!lrst_ff[1]) begin
      ltog_ff <= '0;
    end else begin
      ltog_ff <= ltog_ff ^ l_ev;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      mtog1_ff <= '0;
      mtog2_ff <= '0;
      mtog3_ff <= '0;
      idle1_ff <= 1'b0;
      idle2_ff <= 1'b0;
    end else begin
      mtog1_ff <= ltog_ff;
      mtog2_ff <= mtog1_ff;
      mtog3_ff <= mtog2_ff;
      idle1_ff <= LINK_EV_IN.idle_timeout;
      idle2_ff <= idle1_ff;
    end
  end

  assign en = CTRL_IN.module_enable;
  assign ev = (mtog2_ff ^ mtog3_ff) & {`EV_NUM{en}};

  // Glitch filter: a line change is taken only after it outlasts the count.
  assign pin_raw = {SDA_PIN_IN, SCL_PIN_IN};

  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic            s1_ff;
    logic            s2_ff;
    logic            f_ff;
    logic [`GF_W-1:0] cnt_ff;
    always_ff @(posedge CLOCK_IN) begin
      if (!RESETN_IN) begin
        s1_ff  <= `FILT_RST;
        s2_ff  <= `FILT_RST;
        f_ff   <= `FILT_RST;
        cnt_ff <= '0;
      end else begin
        s1_ff <= pin_raw[i];
        s2_ff <= s1_ff;
        if (s2_ff == f_ff) begin
          cnt_ff <= '0;
        end else if (cnt_ff >= GLITCH_CYCLES_IN) begin
          f_ff   <= s2_ff;
          cnt_ff <= '0;
        end else begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
    end
    assign pin_filt[i] = f_ff;
  end

  assign SCL_FILT_OUT = pin_filt[0];
  assign SDA_FILT_OUT = pin_filt[1];

  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    w1c = set | (cur & ~clr);
  endfunction

  // Sources other than transfer done; arbitration loss and clock-low timeout have no extra enable.
  always_comb begin
    cpu_src = (ev[`EV_ADDR] & (~CTRL_IN.low_power | CTRL_IN.wakeup_enable)) |
              ev[`EV_ARB] | ev[`EV_LOWTO] |
              ((ev[`EV_START] | ev[`EV_STOP]) & CTRL_IN.start_stop_irq_enable) |
              (ev[`EV_HOLDTO] & CTRL_IN.clk_high_data_low_irq_enable);
  end

  // Hardware set always beats a software clear landing in the same cycle.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.bus_event_flag = w1c(st_ff.bus_event_flag, cpu_src | ev[`EV_DONE],
                                CLR_IN.bus_event);
    nxt_st.transfer_done_flag = w1c(st_ff.transfer_done_flag, ev[`EV_DONE],
                                    CLR_IN.data_access);
    nxt_st.addressed_as_slave_flag = w1c(st_ff.addressed_as_slave_flag, ev[`EV_ADDR],
                                         CLR_IN.addressed_as_slave);
    nxt_st.arbitration_lost_flag = w1c(st_ff.arbitration_lost_flag, ev[`EV_ARB],
                                       CLR_IN.arbitration_lost);
    nxt_st.start_seen_flag = w1c(st_ff.start_seen_flag, ev[`EV_START], CLR_IN.start_seen);
    nxt_st.stop_seen_flag = w1c(st_ff.stop_seen_flag, ev[`EV_STOP], CLR_IN.stop_seen);
    nxt_st.clock_low_timeout_flag = w1c(st_ff.clock_low_timeout_flag, ev[`EV_LOWTO],
                                        CLR_IN.clock_low_timeout);
    nxt_st.clk_high_data_low_timeout_flag = w1c(st_ff.clk_high_data_low_timeout_flag,
                                                ev[`EV_HOLDTO], CLR_IN.clk_high_data_low);
    nxt_st.bus_idle_timeout_flag = idle2_ff & en;
    nxt_oth_pend = w1c(oth_pend_ff, cpu_src, CLR_IN.bus_event);
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      st_ff       <= '0;
      oth_pend_ff <= `FLAG_RST;
    end else begin
      st_ff       <= nxt_st;
      oth_pend_ff <= nxt_oth_pend;
    end
  end

  // The idle flag is left out of the request on purpose: it only reports bus state.
  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= en & CTRL_IN.bus_irq_enable &
                ((st_ff.bus_event_flag & (oth_pend_ff | ~CTRL_IN.dma_request_enable)) |
                 st_ff.clock_low_timeout_flag);
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      dma_ff <= 1'b0;
    end else begin
      dma_ff <= en & CTRL_IN.bus_irq_enable & CTRL_IN.dma_request_enable &
                st_ff.transfer_done_flag;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RESETN_IN) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= en & CTRL_IN.low_power & ~CTRL_IN.smbus_mode & CTRL_IN.bus_irq_enable &
                 CTRL_IN.wakeup_enable & st_ff.addressed_as_slave_flag;
    end
  end

  assign IRQ_OUT     = irq_ff;
  assign DMA_REQ_OUT = dma_ff;
  assign WAKE_OUT    = wake_ff;
  assign STATUS_OUT  = st_ff;

  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  irq_mask_a: assert property (!CTRL_IN.bus_irq_enable |=> !IRQ_OUT)
    else $error("Interrupt raised while enable clear.");
  event_hold_a: assert property (STATUS_OUT.bus_event_flag && !CLR_IN.bus_event
    |=> STATUS_OUT.bus_event_flag)
    else $error("Event flag dropped without a clear.");
  low_timeout_irq_a: assert property (STATUS_OUT.clock_low_timeout_flag && en &&
    CTRL_IN.bus_irq_enable |=> IRQ_OUT)
    else $error("Clock-low timeout did not interrupt.");
  stop_gate_a: assert property (ev == (`EV_NUM'(1) << `EV_STOP) &&
    !CTRL_IN.start_stop_irq_enable && !STATUS_OUT.bus_event_flag
    |=> STATUS_OUT.stop_seen_flag && !STATUS_OUT.bus_event_flag)
    else $error("Stop flag or gating wrong.");
  hold_gate_a: assert property (ev == (`EV_NUM'(1) << `EV_HOLDTO) &&
    !CTRL_IN.clk_high_data_low_irq_enable && !STATUS_OUT.bus_event_flag
    |=> !STATUS_OUT.bus_event_flag)
    else $error("Masked hold timeout set event flag.");
  done_set_a: assert property (ev[`EV_DONE] |=> STATUS_OUT.transfer_done_flag
    ##1 (!CTRL_IN.dma_request_enable || !CTRL_IN.bus_irq_enable || DMA_REQ_OUT))
    else $error("Transfer done not flagged.");
  // A clear with no new completion must empty the transfer flag in one cycle.
  done_clear_a: assert property (CLR_IN.data_access && !ev[`EV_DONE]
    |=> !STATUS_OUT.transfer_done_flag)
    else $error("Transfer done survived its clear.");
  addr_set_a: assert property (ev[`EV_ADDR] |=> STATUS_OUT.addressed_as_slave_flag)
    else $error("Address match not flagged.");
  arb_set_a: assert property (ev[`EV_ARB]
    |=> STATUS_OUT.arbitration_lost_flag && STATUS_OUT.bus_event_flag)
    else $error("Arbitration loss not flagged.");
  low_set_a: assert property (ev[`EV_LOWTO]
    |=> STATUS_OUT.clock_low_timeout_flag && STATUS_OUT.bus_event_flag)
    else $error("Clock-low timeout not flagged.");
  low_hold_a: assert property (STATUS_OUT.clock_low_timeout_flag &&
    !CLR_IN.clock_low_timeout |=> STATUS_OUT.clock_low_timeout_flag)
    else $error("Clock-low flag dropped without a clear.");
  // The idle flag carries no memory: it mirrors the synchronised level, gated by en, each cycle.
  idle_follow_a: assert property (STATUS_OUT.bus_idle_timeout_flag ==
    $past(idle2_ff && en))
    else $error("Idle flag does not follow the bus.");
  wake_gate_a: assert property (!CTRL_IN.low_power |=> !WAKE_OUT)
    else $error("Wake outside low power.");
  dma_gate_a: assert property (!CTRL_IN.dma_request_enable |=> !DMA_REQ_OUT)
    else $error("DMA request with DMA disabled.");
  // A disabled block must stay silent whatever flags were left behind.
  off_quiet_a: assert property (!en
    |=> !IRQ_OUT && !DMA_REQ_OUT && !WAKE_OUT)
    else $error("Request from a disabled block.");
  arb_hold_a: assert property (STATUS_OUT.arbitration_lost_flag &&
    !CLR_IN.arbitration_lost |=> STATUS_OUT.arbitration_lost_flag)
    else $error("Arbitration flag dropped without a clear.");
  idle_quiet_a: assert property (!STATUS_OUT.bus_event_flag &&
    !STATUS_OUT.clock_low_timeout_flag |=> !IRQ_OUT)
    else $error("Interrupt without a flag.");
  dma_only_a: assert property (CTRL_IN.dma_request_enable && !oth_pend_ff &&
    !STATUS_OUT.clock_low_timeout_flag |=> !IRQ_OUT)
    else $error("Transfer done interrupted in DMA mode.");
  smbus_wake_a: assert property (CTRL_IN.smbus_mode |=> !WAKE_OUT)
    else $error("Wake in bus management mode.");
  wake_cause_a: assert property ($rose(WAKE_OUT) |-> $past(CTRL_IN.wakeup_enable) &&
    $past(STATUS_OUT.addressed_as_slave_flag))
    else $error("Wake without enable or match.");

  // Covers for the main paths: DMA, wake, interrupt, stop and a filtered edge.
  cov_dma_c: cover property (ev[`EV_DONE] ##[1:3] DMA_REQ_OUT);
  cov_wake_c: cover property (ev[`EV_ADDR] ##[1:3] WAKE_OUT);
  cov_irq_c: cover property (ev[`EV_ARB] ##[1:3] IRQ_OUT);
  cov_stop_c: cover property (ev[`EV_STOP] ##1 STATUS_OUT.stop_seen_flag);
  cov_filt_c: cover property ($fell(SDA_FILT_OUT) && SCL_FILT_OUT);

endmodule

//--- tb/bus_peer_model.sv
`timescale 1ns/1ns
module bus_peer_model (
  input  wire logic             link_clk_in,
  output i2c_evt_pkg::link_ev_t ev_out
);
  import i2c_evt_pkg::*;
  initial begin
    ev_out = '0;
  end
  // One link cycle per event, then a gap; a long gap plays a slow master.
  task automatic pulse(input link_ev_t v, input int gap);
    @(posedge link_clk_in);
    ev_out <= v | link_ev_t'({13'h0, ev_out.idle_timeout});
    @(posedge link_clk_in);
    ev_out <= link_ev_t'({13'h0, ev_out.idle_timeout});
    repeat (gap) @(posedge link_clk_in);
  endtask
  task automatic set_idle(input logic v);
    @(posedge link_clk_in);
    ev_out.idle_timeout <= v;
  endtask
endmodule

//--- tb/i2c_event_irq_dma_wakeup_tb.sv
`timescale 1ns/1ns
`include "i2c_evt_consts.svh"
module i2c_event_irq_dma_wakeup_tb;
  import i2c_evt_pkg::*;
  logic             clk, lclk, rstn, scl, sda, scl_f, sda_f, irq, dma, wake, low;
  logic [`GF_W-1:0] gcyc;
  logic [31:0]      r;
  ctrl_t            ctrl, c;
  clr_t             clr;
  link_ev_t         ev;
  status_t          st, s;
  int               mismatches, total_checks, k;
  integer           seed;
  i2c_event_irq_dma_wakeup DUT (.CLOCK_IN(clk), .RESETN_IN(rstn), .LINK_CLK_IN(lclk),
    .LINK_EV_IN(ev), .CTRL_IN(ctrl), .CLR_IN(clr), .GLITCH_CYCLES_IN(gcyc), .SCL_PIN_IN(scl),
    .SDA_PIN_IN(sda), .SCL_FILT_OUT(scl_f), .SDA_FILT_OUT(sda_f), .IRQ_OUT(irq),
    .DMA_REQ_OUT(dma), .WAKE_OUT(wake), .STATUS_OUT(st));
  bus_peer_model peer (.link_clk_in(lclk), .ev_out(ev));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #40 lclk = ~lclk;
  end
  function automatic status_t exp_st(input ctrl_t c, input link_ev_t e);
    status_t x;
    x = '0;
    x.transfer_done_flag = c.fast_ack_enable ? e.fall8 : e.fall9;
    x.addressed_as_slave_flag = e.addr_match | (e.general_call & c.general_call_enable);
    x.arbitration_lost_flag = |{e.arb_data_low, e.arb_ack_low, e.arb_start_busy,
                                e.arb_rstart_slave, e.arb_unreq_stop};
    x.start_seen_flag = e.start_det;
    x.stop_seen_flag = e.stop_det;
    x.clock_low_timeout_flag = e.low_timeout;
    x.clk_high_data_low_timeout_flag = e.high_low_timeout;
    x.bus_event_flag = x.transfer_done_flag | x.arbitration_lost_flag | e.low_timeout
      | (x.addressed_as_slave_flag & (!c.low_power | c.wakeup_enable))
      | (c.start_stop_irq_enable & (e.start_det | e.stop_det))
      | (c.clk_high_data_low_irq_enable & e.high_low_timeout);
    return c.module_enable ? x : '0;
  endfunction
  function automatic logic [2:0] exp_out(input ctrl_t c, input status_t x);
    logic on, oth;
    on = c.module_enable & c.bus_irq_enable;
    oth = x.addressed_as_slave_flag | x.arbitration_lost_flag | x.clock_low_timeout_flag
      | (c.start_stop_irq_enable & (x.start_seen_flag | x.stop_seen_flag))
      | (c.clk_high_data_low_irq_enable & x.clk_high_data_low_timeout_flag);
    return {on & ((x.bus_event_flag & (oth | !c.dma_request_enable)) | x.clock_low_timeout_flag),
      on & c.dma_request_enable & x.transfer_done_flag & x.bus_event_flag,
      on & c.low_power & !c.smbus_mode & c.wakeup_enable & x.addressed_as_slave_flag};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic clear(input clr_t v);
    @(posedge clk) clr <= v;
    @(posedge clk) clr <= '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic fire(input link_ev_t e);
    @(posedge clk) ctrl <= c;
    repeat (16) @(posedge clk);
    peer.pulse(e, $unsigned($random(seed)) % 3);
    repeat (14) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic glitch_try(input int w);
    low = 1'b0;
    @(posedge clk);
    fork
      begin
        scl <= 1'b0;
        sda <= 1'b0;
        repeat (w) @(posedge clk);
        scl <= 1'b1;
        sda <= 1'b1;
      end
      repeat (w + 12) @(negedge clk) if (scl_f !== 1'b1 || sda_f !== 1'b1) low = 1'b1;
    join
    check(low, w > gcyc, "glitch");
    repeat (gcyc + 12) @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    seed = 32'h8859;
    {rstn, scl, sda, ctrl, clr, gcyc} = '0;
    {scl, sda} = 2'b11;
    repeat (16) @(posedge clk);
    @(negedge clk);
    check({st, irq, dma, wake, scl_f, sda_f}, 14'h3, "reset");
    @(posedge clk) rstn <= 1'b1;
    // Corner sweep of every event in run and low power modes; bus management mode sees every other event.
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      c = r[9:0];
      k = (i < 26) ? (i % 13) + 1 : 1 + $unsigned($random(seed)) % 13;
      if (i < 26) begin
        // Corners stay a receiving slave; DMA is toggled only between bytes.
        c = 10'h3f8 | {7'h0, i[2], i >= 13 && i[0], i >= 13};
        c.fast_ack_enable = i[1];
      end
      fire(link_ev_t'(14'h1 << k));
      s = exp_st(c, link_ev_t'(14'h1 << k));
      check(st, s, "flags");
      check({irq, dma, wake}, exp_out(c, s), "irq");
      clear('1);
    end
    $display("Event sweep done");
    c = 10'h3c0;
    fire(link_ev_t'(14'h200));
    repeat (40) @(posedge clk);
    clear(clr_t'(8'h80));
    check({st.bus_event_flag, st.arbitration_lost_flag, irq}, 3'h2, "held");
    clear(clr_t'(8'h20));
    check(st.arbitration_lost_flag, 1'b0, "arb clear");
    fire(link_ev_t'(14'h4));
    clear(clr_t'(8'h80));
    check({st.clock_low_timeout_flag, irq}, 2'h3, "low hold");
    clear(clr_t'(8'h40));
    check({st.clock_low_timeout_flag, irq}, 2'h0, "low clear");
    peer.set_idle(1'b1);
    repeat (14) @(posedge clk);
    @(negedge clk);
    check({st, irq}, 10'h2, "idle");
    peer.set_idle(1'b0);
    repeat (14) @(posedge clk);
    @(negedge clk);
    check({st, irq}, 10'h0, "idle off");
    $display("Flag hold done");
    for (int j = 0; j < 6; j++) begin
      r = $random(seed);
      @(posedge clk) gcyc <= (j == 0) ? '0 : `GF_W'(r[2:0] + 3'h1);
      repeat (3) @(posedge clk);
      glitch_try((gcyc == '0) ? 1 : int'(gcyc));
      glitch_try(gcyc + 1);
    end
    $display("Glitch filter done");
    tally_and_finish;
  end
endmodule
